/* design/ssbc_top.sv */
// System state machine and reserve boost control with Wishbone slave
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/10ps

// What this block does
// - Reset output release puts the state machine in Init.
// - Watchdog window register writable only while in Init.
// - First good watchdog feed moves Init to Diag.
// - Safing records and deployment masks writable only in Diag.
// - Diag tests are mutually exclusive; at most one runs.
// - Squib switch test commands run only in Diag, else ignored.
// - Safing transistor test runs only in Diag.
// - Diag is held until a safing or scrap command.
// - Safing command in Diag moves to Safing state.
// - Safing state enables safing logic and deployment permission output.
// - Safing is left only through system state machine reset.
// - Scrap command in Diag moves to Scrap state.
// - Scrap disables remote sensor monitoring and safing logic.
// - Scrap only goes to Arming; Init only via reset.
// - Arming output asserted throughout the Arming state.
// - Arming time-out without valid line signal returns to Scrap.
// - Wake released plus sleep command enters passive mode at once.
// - Boost setpoint 23 V at reset; host may select 33 V.
// - Host may disable the boost converter; disable is honoured.
// - Boost undervoltage reported in a power state flag.
// - Thermal fault latches switch off until fault register read.
// - Ground loss turns switch off, restores it automatically.
// - Passive mode turns boost off unless hold bit is 1.
// - System reset from power-on, watchdog reset or watchdog failure.
// - Fault status latches clear on host read.
module ssbc_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por_in,
  input wire logic watchdog_fsm_reset,
  input wire logic wd_fail,
  input wire logic wd_feed_ok,
  input wire logic wake_in,
  input wire logic arm_req,
  input wire logic arm_timeout,
  input wire logic extra_comm_line_ok,
  input wire logic boost_ot_in,
  input wire logic gnd_lost_in,
  input wire logic boost_uv_in,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic reset_out_n,
  output ssbc_pkg::ssbc_state_t state_o,
  output ssbc_pkg::ssbc_boost_t boost_o,
  output logic [ssbc_pkg::TEST_W-1:0] test_run_o,
  output logic safing_en_o,
  output logic deploy_perm_o,
  output logic rsens_mon_en_o,
  output logic arm_o,
  output logic passive_o,
  output logic cfg_wr_o
);
  import ssbc_pkg::*;

  // ****************************************
  // System reset and bus decode
  // ****************************************
  // Reset request is combinational so it reaches the FSM in the same edge
  logic system_fsm_reset;
  assign system_fsm_reset = por_in | watchdog_fsm_reset | wd_fail;

  logic req, wr, rd;
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  // Writes land on the edge where the master samples ack, never earlier
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  logic mapped;
  always_comb begin
    case (wb_adr_i)
      ADDR_SYSTEM_CONTROL_REG, ADDR_SYSTEM_CONFIG_REG, ADDR_CMD, ADDR_STATE,
      ADDR_PWR, ADDR_FLT, ADDR_WD: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ssbc_state_t state_r, state_nxt;
  logic [1:0] system_control_reg;
  logic system_config_reg;
  logic [WD_W-1:0] wd_window_r;
  logic passive_r;
  logic [2:0] fault_status_reg;
  logic cmd_wr;
  assign cmd_wr = wr && (wb_adr_i == ADDR_CMD);

  // ****************************************
  // System operating state machine
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: if (wd_feed_ok) state_nxt = ST_DIAG;
      ST_DIAG: begin
        // Safing wins if both commands are written together
        if (cmd_wr && wb_dat_i[CMD_SAFING]) begin
          state_nxt = ST_SAFING;
        end else if (cmd_wr && wb_dat_i[CMD_SCRAP]) begin
          state_nxt = ST_SCRAP;
        end
      end
      ST_SAFING: state_nxt = ST_SAFING;
      ST_SCRAP: if (arm_req) state_nxt = ST_ARMING;
      ST_ARMING: begin
        if (arm_timeout && !extra_comm_line_ok) begin
          state_nxt = ST_SCRAP;
        end
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= ST_INIT;
    end else if (system_fsm_reset) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // State outputs
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_o <= ST_INIT;
      reset_out_n <= 1'b0;
      safing_en_o <= 1'b0;
      deploy_perm_o <= 1'b0;
      rsens_mon_en_o <= 1'b0;
      arm_o <= 1'b0;
    end else begin
      state_o <= state_r;
      reset_out_n <= ~system_fsm_reset;
      safing_en_o <= (state_r == ST_SAFING);
      deploy_perm_o <= (state_r == ST_SAFING);
      rsens_mon_en_o <= (state_r != ST_SCRAP) &&
                        (state_r != ST_ARMING);
      arm_o <= (state_r == ST_ARMING);
    end
  end

  // ****************************************
  // Diagnostic tests
  // ****************************************
  // Bit 0 high-side switch, bit 1 low-side switch, bit 2 safing FET test
  logic [TEST_W-1:0] treq;
  assign treq = wb_dat_i[CMD_TEST0 +: TEST_W];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_run_o <= '0;
    end else if (state_r != ST_DIAG || system_fsm_reset) begin
      test_run_o <= '0;
    end else if (cmd_wr) begin
      // Lowest set bit wins so that only one test ever runs
      test_run_o <= treq & (~treq + TEST_W'(1));
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wd_window_r <= WD_RST;
    end else if (wr && wb_adr_i == ADDR_WD && state_r == ST_INIT) begin
      wd_window_r <= wb_dat_i[WD_W-1:0];
    end
  end

  // Strobe to the safing record and mask storage; only honoured in Diag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_wr_o <= 1'b0;
    end else begin
      cfg_wr_o <= wr && wb_adr_i == ADDR_SYSTEM_CONFIG_REG &&
                  state_r == ST_DIAG;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      system_control_reg <= CTL_RST;
      system_config_reg <= CFG_RST;
    end else begin
      if (wr && wb_adr_i == ADDR_SYSTEM_CONTROL_REG) begin
        system_control_reg <= wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == ADDR_SYSTEM_CONFIG_REG && state_r == ST_DIAG) begin
        system_config_reg <= wb_dat_i[CFG_HOLD_BST];
      end
    end
  end

  // ****************************************
  // Power mode
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      passive_r <= 1'b0;
    end else if (cmd_wr && wb_dat_i[CMD_SLEEP] && !wake_in) begin
      passive_r <= 1'b1;
    end
  end

  // ****************************************
  // Boost faults and enable
  // ****************************************
  logic flt_rd;
  assign flt_rd = rd && wb_adr_i == ADDR_FLT;
  logic [2:0] flt_set;
  assign flt_set = {por_in, wd_fail | watchdog_fsm_reset, boost_ot_in};
  // Set beats the read clear so no event is lost
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_status_reg <= '0;
    end else if (flt_rd) begin
      fault_status_reg <= flt_set;
    end else begin
      fault_status_reg <= fault_status_reg | flt_set;
    end
  end

  logic hold_boost_in_passive;
  assign hold_boost_in_passive = system_config_reg;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      boost_o <= '0;
      passive_o <= 1'b0;
    end else begin
      boost_o.sel_33v <= system_control_reg[CTL_BST_33V];
      boost_o.en <= !system_control_reg[CTL_BST_DIS] &&
                    !fault_status_reg[FLT_BST_OT] &&
                    !boost_ot_in &&
                    !gnd_lost_in &&
                    !(passive_r && !hold_boost_in_passive);
      passive_o <= passive_r;
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    case (wb_adr_i)
      ADDR_SYSTEM_CONTROL_REG: rdata[1:0] = system_control_reg;
      ADDR_SYSTEM_CONFIG_REG: rdata[0] = system_config_reg;
      ADDR_STATE: rdata[2:0] = state_r;
      ADDR_PWR: rdata[1:0] = {passive_r, boost_uv_in};
      ADDR_FLT: rdata[2:0] = fault_status_reg;
      ADDR_WD: rdata[WD_W-1:0] = wd_window_r;
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= rd ? rdata : '0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_safe_stay;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_SAFING && !system_fsm_reset) |=> state_r == ST_SAFING;
  endproperty
  a_safe_stay: assert property (p_safe_stay)
    else $error("Safing state left without reset");

  property p_arm_out;
    @(posedge clk_sys) disable iff (rst)
    state_r == ST_ARMING |=> arm_o;
  endproperty
  a_arm_out: assert property (p_arm_out)
    else $error("Arm output low in arming state");

  property p_one_test;
    @(posedge clk_sys) disable iff (rst) $onehot0(test_run_o);
  endproperty
  a_one_test: assert property (p_one_test)
    else $error("More than one test running");

  property p_test_diag;
    @(posedge clk_sys) disable iff (rst)
    (test_run_o != '0) |-> $past(state_r) == ST_DIAG;
  endproperty
  a_test_diag: assert property (p_test_diag)
    else $error("Test running outside diag");

  property p_init_diag;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_INIT && wd_feed_ok && !system_fsm_reset)
      |=> state_r == ST_DIAG;
  endproperty
  a_init_diag: assert property (p_init_diag)
    else $error("Feed did not enter diag");

  property p_scrap_exit;
    @(posedge clk_sys) disable iff (rst)
    (state_r == ST_SCRAP && !system_fsm_reset)
      |=> state_r inside {ST_SCRAP, ST_ARMING};
  endproperty
  a_scrap_exit: assert property (p_scrap_exit)
    else $error("Illegal exit from scrap");

  property p_ot_off;
    @(posedge clk_sys) disable iff (rst)
    boost_ot_in |=> !boost_o.en ##1 !boost_o.en;
  endproperty
  a_ot_off: assert property (p_ot_off)
    else $error("Boost on after thermal fault");

  property p_pass_off;
    @(posedge clk_sys) disable iff (rst)
    (passive_r && !system_config_reg) |=> !boost_o.en;
  endproperty
  a_pass_off: assert property (p_pass_off)
    else $error("Boost on in passive mode");

  property p_rst_init;
    @(posedge clk_sys) disable iff (rst)
    system_fsm_reset |=> state_r == ST_INIT && !reset_out_n;
  endproperty
  a_rst_init: assert property (p_rst_init)
    else $error("System reset did not return to init");

  property p_cfg_diag;
    @(posedge clk_sys) disable iff (rst)
    cfg_wr_o |-> $past(state_r) == ST_DIAG;
  endproperty
  a_cfg_diag: assert property (p_cfg_diag)
    else $error("Config strobe outside diag");

  property p_scrap_mon;
    @(posedge clk_sys) disable iff (rst)
    state_r == ST_SCRAP |=> !rsens_mon_en_o && !safing_en_o;
  endproperty
  a_scrap_mon: assert property (p_scrap_mon)
    else $error("Monitoring active in scrap");

  property p_wd_lock;
    @(posedge clk_sys) disable iff (rst)
    state_r != ST_INIT |=> $stable(wd_window_r);
  endproperty
  a_wd_lock: assert property (p_wd_lock)
    else $error("Watchdog window changed outside init");

  property p_sleep;
    @(posedge clk_sys) disable iff (rst)
    (cmd_wr && wb_dat_i[CMD_SLEEP] && !wake_in) |=> passive_r;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("Sleep command did not enter passive");

  property p_gnd_off;
    @(posedge clk_sys) disable iff (rst)
    gnd_lost_in |=> !boost_o.en;
  endproperty
  a_gnd_off: assert property (p_gnd_off)
    else $error("Boost on while ground lost");

endmodule : ssbc_top

/* design/ssbc_pkg.sv */
// Package for the system state and boost control block
package ssbc_pkg;

  // ****************************************
  // Register map (word byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_SYSTEM_CONTROL_REG = 8'h00;
  localparam logic [7:0] ADDR_SYSTEM_CONFIG_REG = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0C;
  localparam logic [7:0] ADDR_PWR = 8'h10;
  localparam logic [7:0] ADDR_FLT = 8'h14;
  localparam logic [7:0] ADDR_WD = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_BST_33V = 0;
  localparam int CTL_BST_DIS = 1;
  localparam int CFG_HOLD_BST = 0;
  localparam int CMD_SAFING = 0;
  localparam int CMD_SCRAP = 1;
  localparam int CMD_SLEEP = 2;
  localparam int CMD_TEST0 = 4;
  localparam int TEST_W = 3;
  localparam int FLT_BST_OT = 0;
  localparam int FLT_WD = 1;
  localparam int FLT_POR = 2;
  localparam int WD_W = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] CTL_RST = 2'h0;
  localparam logic CFG_RST = 1'b0;
  localparam logic [15:0] WD_RST = 16'h0100;

  typedef enum logic [2:0] {
    ST_INIT, ST_DIAG, ST_SAFING, ST_SCRAP, ST_ARMING
  } ssbc_state_t;

  typedef struct packed {
    logic en;
    logic sel_33v;
  } ssbc_boost_t;

  typedef struct packed {
    logic ot;
    logic gnd_lost;
    logic uv;
  } ssbc_bfault_t;

endpackage : ssbc_pkg

/* test/ssbc_host_model.sv */
// Host side Wishbone master model for the state and boost bench
`timescale 1ns/10ps
module ssbc_host_model (
  input wire logic clk_sys,
  output logic [7:0] wb_adr_i,
  output logic [31:0] wb_dat_i,
  output logic [3:0] wb_sel_i,
  output logic wb_we_i,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o
);
  initial begin
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
  end

  // Window and boost settings reach the block only this way
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e,
      output logic tmo);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && n < 50);
    q = wb_dat_o;
    e = wb_err_o;
    tmo = (n >= 50);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // Released lines flip so stale values are never taken as live
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
    wb_sel_i <= 4'h0;
  endtask : xfer
endmodule : ssbc_host_model

/* test/tb_top.sv */
// Self-checking bench for the state and boost control block
`timescale 1ns/10ps
module tb_top;
  import ssbc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic por_in = 1'b0;
  logic watchdog_fsm_reset = 1'b0;
  logic wd_fail = 1'b0;
  logic wd_feed_ok = 1'b0;
  logic wake_in = 1'b1;
  logic arm_req = 1'b0;
  logic arm_timeout = 1'b0;
  logic extra_comm_line_ok = 1'b0;
  logic boost_ot_in = 1'b0;
  logic gnd_lost_in = 1'b0;
  logic boost_uv_in = 1'b0;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [3:0] wb_sel_i;
  logic wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, e, t;
  logic reset_out_n, safing_en_o, deploy_perm_o, rsens_mon_en_o;
  logic arm_o, passive_o, cfg_wr_o;
  ssbc_state_t state_o;
  ssbc_boost_t boost_o;
  logic [TEST_W-1:0] test_run_o;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'he4a7_68f7;
  int m_wd;
  int m_state = 0;
  int cfg_seen = 0;

  always #10 clk_sys = ~clk_sys;

  ssbc_top ssbc_top_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .por_in(por_in),
    .watchdog_fsm_reset(watchdog_fsm_reset),
    .wd_fail(wd_fail),
    .wd_feed_ok(wd_feed_ok),
    .wake_in(wake_in),
    .arm_req(arm_req),
    .arm_timeout(arm_timeout),
    .extra_comm_line_ok(extra_comm_line_ok),
    .boost_ot_in(boost_ot_in),
    .gnd_lost_in(gnd_lost_in),
    .boost_uv_in(boost_uv_in),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o),
    .reset_out_n(reset_out_n),
    .state_o(state_o),
    .boost_o(boost_o),
    .test_run_o(test_run_o),
    .safing_en_o(safing_en_o),
    .deploy_perm_o(deploy_perm_o),
    .rsens_mon_en_o(rsens_mon_en_o),
    .arm_o(arm_o),
    .passive_o(passive_o),
    .cfg_wr_o(cfg_wr_o)
  );
  ssbc_host_model ssbc_host_model_inst (
    .clk_sys(clk_sys),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o)
  );

  // Config strobe is one cycle wide, so it is counted where it stands
  always @(posedge clk_sys) begin
    if (cfg_wr_o === 1'b1) cfg_seen++;
  end

  // ****************************************
  // Checking and bus helpers
  // ****************************************
  task automatic final_report();
    $display("Compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t pin got %h exp %h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic bus(input logic w, input logic [7:0] a, input int d);
    ssbc_host_model_inst.xfer(w, a, d, q, e, t);
    if (t) begin
      mismatches++;
      final_report();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input int d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input int m, input int x);
    bus(1'b0, a, 0);
    chk_reg(q & m, x);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask : settle

  // State model: 0 feed, 1 arm request, 2 time-out, 3 command, 4 reset
  task automatic m_event(input int k, input int d);
    case (k)
      0: if (m_state == ST_INIT) m_state = ST_DIAG;
      1: if (m_state == ST_SCRAP) m_state = ST_ARMING;
      2: if (m_state == ST_ARMING && !extra_comm_line_ok) m_state = ST_SCRAP;
      3: begin
        if (m_state == ST_DIAG && d[0]) begin
          m_state = ST_SAFING;
        end else if (m_state == ST_DIAG && d[1]) begin
          m_state = ST_SCRAP;
        end
      end
      default: m_state = ST_INIT;
    endcase
  endtask : m_event

  task automatic cmd(input int d);
    wr(ADDR_CMD, d);
    m_event(3, d);
  endtask : cmd

  // Pulse inputs: 0 feed, 1 arm request, 2 time-out, 3 overtemp, 4 por, 5 fail
  task automatic pulse(input int k);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_sys);
      case (k)
        0: wd_feed_ok <= v[0];
        1: arm_req <= v[0];
        2: arm_timeout <= v[0];
        3: boost_ot_in <= v[0];
        4: por_in <= v[0];
        default: wd_fail <= v[0];
      endcase
    end
    settle();
    if (k != 3) m_event((k > 3) ? 4 : k, 0);
  endtask : pulse

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    m_state = ST_INIT;
    settle();
    chk_pin(state_o, 8'(m_state));
    chk_pin(reset_out_n, 8'h01);
    chk_pin(boost_o, 8'h02);
    rd(ADDR_SYSTEM_CONTROL_REG, '1, CTL_RST);
    rd(ADDR_WD, '1, WD_RST);
    m_wd = $random(seed) & 32'h0000_ffff;
    wr(ADDR_WD, m_wd);
    rd(ADDR_WD, '1, m_wd);
    wr(ADDR_SYSTEM_CONFIG_REG, 1);
    rd(ADDR_SYSTEM_CONFIG_REG, '1, 0);
    chk_pin(8'(cfg_seen), 8'h00);
    cmd(32'h0000_0070);
    settle();
    chk_pin(test_run_o, 8'h00);
    bus(1'b0, 8'h40, 0);
    chk_pin(e, 8'h01);
    pulse(0);
    rd(ADDR_STATE, '1, m_state);
    wr(ADDR_WD, ~m_wd);
    rd(ADDR_WD, '1, m_wd);
    for (int i = 0; i < TEST_W; i++) begin
      cmd(32'h10 << i);
      settle();
      chk_pin(test_run_o, 8'(1 << i));
    end
    cmd(32'h0000_0060);
    settle();
    chk_pin(test_run_o, 8'h02);
    rd(ADDR_STATE, '1, m_state);
    wr(ADDR_SYSTEM_CONFIG_REG, 1);
    rd(ADDR_SYSTEM_CONFIG_REG, '1, 1);
    chk_pin(8'(cfg_seen), 8'h01);
    wr(ADDR_SYSTEM_CONTROL_REG, 1);
    settle();
    chk_pin(boost_o, 8'h03);
    wr(ADDR_SYSTEM_CONTROL_REG, 3);
    settle();
    chk_pin(boost_o.en, 8'h00);
    wr(ADDR_SYSTEM_CONTROL_REG, 1);
    pulse(3);
    chk_pin(boost_o.en, 8'h00);
    rd(ADDR_FLT, 1, 1);
    settle();
    chk_pin(boost_o.en, 8'h01);
    rd(ADDR_FLT, 1, 0);
    gnd_lost_in <= 1'b1;
    settle();
    chk_pin(boost_o.en, 8'h00);
    gnd_lost_in <= 1'b0;
    settle();
    chk_pin(boost_o.en, 8'h01);
    boost_uv_in <= 1'b1;
    settle();
    rd(ADDR_PWR, 1, 1);
    boost_uv_in <= 1'b0;
    rd(ADDR_PWR, 1, 0);
    cmd(3);
    settle();
    rd(ADDR_STATE, '1, m_state);
    chk_pin({safing_en_o, deploy_perm_o}, 8'h03);
    cmd(32'h0000_0012);
    settle();
    rd(ADDR_STATE, '1, m_state);
    chk_pin(test_run_o, 8'h00);
    cmd(4);
    settle();
    chk_pin(passive_o, 8'h00);
    wake_in <= 1'b0;
    cmd(4);
    settle();
    chk_pin({passive_o, boost_o.en}, 8'h03);
    watchdog_fsm_reset <= 1'b1;
    settle();
    m_event(4, 0);
    chk_pin({reset_out_n, state_o}, 8'(m_state));
    watchdog_fsm_reset <= 1'b0;
    settle();
    rd(ADDR_FLT, 2, 2);
    rd(ADDR_FLT, 2, 0);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    m_state = ST_INIT;
    pulse(0);
    cmd(2);
    settle();
    chk_pin(state_o, 8'(m_state));
    chk_pin({rsens_mon_en_o, safing_en_o}, 8'h00);
    cmd(1);
    settle();
    chk_pin(state_o, 8'(m_state));
    pulse(1);
    chk_pin(state_o, 8'(m_state));
    chk_pin(arm_o, 8'h01);
    extra_comm_line_ok <= 1'b1;
    pulse(2);
    chk_pin(state_o, 8'(m_state));
    chk_pin(arm_o, 8'h01);
    extra_comm_line_ok <= 1'b0;
    pulse(2);
    chk_pin(state_o, 8'(m_state));
    chk_pin(arm_o, 8'h00);
    pulse(1);
    pulse(4);
    chk_pin(state_o, 8'(m_state));
    chk_pin(arm_o, 8'h00);
    cmd(4);
    settle();
    chk_pin({passive_o, boost_o.en}, 8'h02);
    pulse(0);
    pulse(5);
    chk_pin(state_o, 8'(m_state));
    final_report();
  end
endmodule : tb_top
